// >>> coa_pkg.sv
// Package of types, constants and helper functions for the operand addressing core
// ****************************************************************
// ****************************************************************
package coa_pkg;

  // ****************************************************************
  // Operations, modes and sizes
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LOAD = 5'h01, OP_STORE = 5'h02, OP_MOV_IMM = 5'h03,
    OP_ADD = 5'h04, OP_ADD_IMM = 5'h05, OP_COMPARE_GREATER_EQUAL = 5'h06, OP_COMPARE_EQUAL = 5'h07,
    OP_COMPARE_EQUAL_IMM = 5'h08, OP_BRA = 5'h09, OP_BT = 5'h0a, OP_BF = 5'h0b,
    OP_MULS_W = 5'h0c, OP_MULU_W = 5'h0d, OP_MAC_W = 5'h0e, OP_DMULS_L = 5'h0f,
    OP_DMULU_L = 5'h10, OP_MAC_L = 5'h11
  } coa_op_t;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'b000, AM_INDIRECT = 3'b001, AM_POSTINC = 3'b010, AM_PREDEC = 3'b011,
    AM_DISP4 = 3'b100, AM_INDEXED = 3'b101, AM_GBR_DISP = 3'b110, AM_PC_DISP = 3'b111
  } coa_mode_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00, SZ_WORD = 2'b01, SZ_LONG = 2'b10
  } coa_size_t;

  typedef enum logic [1:0] {
    ST_READY = 2'b00, ST_MEM = 2'b01, ST_MUL = 2'b10
  } coa_state_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    coa_op_t op;
    coa_mode_t mode;
    coa_size_t size;
    logic [3:0] rn;
    logic [3:0] rm;
    logic [11:0] disp;
    logic [7:0] imm;
  } coa_cmd_t;

  typedef struct packed {
    logic valid;
    logic write;
    coa_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } coa_mem_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } coa_mem_rsp_t;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam int T_BIT = 0;
  localparam logic [31:0] SR_RESET = 32'h0000_00f0;
  localparam logic [31:0] GBR_RESET = 32'h0000_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [31:0] LONG_MASK = 32'hffff_fffc;
  localparam logic [2:0] MUL16_CYCLES = 3'h2;
  localparam logic [2:0] MAC16_CYCLES = 3'h3;
  localparam logic [2:0] MUL32_CYCLES = 3'h4;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Scale a zero-extended displacement by the operand size
  function automatic logic [31:0] scale_disp(input coa_size_t sz, input logic [7:0] d);
    logic [31:0] z;
    z = {24'h00_0000, d};
    case (sz)
      SZ_WORD: scale_disp = {z[30:0], 1'b0};
      SZ_LONG: scale_disp = {z[29:0], 2'b00};
      default: scale_disp = z;
    endcase
  endfunction

  // Byte count of one access
  function automatic logic [31:0] size_step(input coa_size_t sz);
    case (sz)
      SZ_WORD: size_step = 32'h0000_0002;
      SZ_LONG: size_step = 32'h0000_0004;
      default: size_step = 32'h0000_0001;
    endcase
  endfunction

  // Sign-extend a loaded operand to a longword
  function automatic logic [31:0] sext_data(input coa_size_t sz, input logic [31:0] v);
    case (sz)
      SZ_BYTE: sext_data = {{24{v[7]}}, v[7:0]};
      SZ_WORD: sext_data = {{16{v[15]}}, v[15:0]};
      default: sext_data = v;
    endcase
  endfunction

endpackage

// >>> coa_ea_unit.sv
// Effective address generator for all operand addressing modes
`timescale 1ns/1ps
module coa_ea_unit (
  input wire coa_pkg::coa_mode_t mode_in, // Addressing mode
  input wire coa_pkg::coa_size_t size_in, // Operand size
  input wire logic [31:0] rn_val_in, // Selected general register
  input wire logic [31:0] r0_val_in, // Index register zero
  input wire logic [31:0] gbr_val_in, // Global base pointer
  input wire logic [31:0] pc_val_in, // Address of this instruction
  input wire logic [7:0] disp_in, // Displacement field
  output logic [31:0] addr_out, // Access address
  output logic [31:0] rn_next_out, // Register value after access
  output logic rn_wr_out, // Register is updated
  output logic misalign_out // Access violates alignment
);

  logic [31:0] step;
  logic [31:0] pc_base;

  // ****************************************************************
  // Address calculation, all sums wrap at 32 bits
  // ****************************************************************
  always_comb
  begin
    step = coa_pkg::size_step(size_in);
    pc_base = pc_val_in + coa_pkg::PC_AHEAD;
    addr_out = rn_val_in;
    rn_next_out = rn_val_in;
    rn_wr_out = 1'b0;
    case (mode_in)
      coa_pkg::AM_POSTINC:
      begin
        rn_next_out = rn_val_in + step;
        rn_wr_out = 1'b1;
      end
      coa_pkg::AM_PREDEC:
      begin
        rn_next_out = rn_val_in - step;
        addr_out = rn_next_out;
        rn_wr_out = 1'b1;
      end
      coa_pkg::AM_DISP4: addr_out = rn_val_in + coa_pkg::scale_disp(size_in, {4'h0, disp_in[3:0]});
      coa_pkg::AM_INDEXED: addr_out = rn_val_in + r0_val_in;
      coa_pkg::AM_GBR_DISP: addr_out = gbr_val_in + coa_pkg::scale_disp(size_in, disp_in);
      coa_pkg::AM_PC_DISP:
      begin
        if (size_in == coa_pkg::SZ_LONG)
          addr_out = (pc_base & coa_pkg::LONG_MASK) + coa_pkg::scale_disp(size_in, disp_in);
        else
          addr_out = pc_base + coa_pkg::scale_disp(size_in, disp_in);
      end
      default: addr_out = rn_val_in;
    endcase
    // Word needs even, longword needs multiple of four
    case (size_in)
      coa_pkg::SZ_WORD: misalign_out = addr_out[0];
      coa_pkg::SZ_LONG: misalign_out = |addr_out[1:0];
      default: misalign_out = 1'b0;
    endcase
  end

endmodule // coa_ea_unit

// >>> coa_mul_unit.sv
// Multiplier and multiply-accumulate unit with fixed cycle counts
`timescale 1ns/1ps
module coa_mul_unit (
  input wire logic clk_in, // Core clock
  input wire logic rst_n_in, // Synchronised reset, active low
  input wire logic start_in, // Start pulse
  input wire coa_pkg::coa_op_t op_in, // Multiply kind
  input wire logic [31:0] a_in, // First operand
  input wire logic [31:0] b_in, // Second operand
  input wire logic [63:0] acc_in, // Accumulator pair
  output logic done_out, // Result ready pulse
  output logic [63:0] result_out // Product or sum
);

  logic [2:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [63:0] res_q, res_d;
  logic [63:0] prod;
  logic [2:0] cycles;

  assign done_out = done_q;
  assign result_out = res_q;

  // ****************************************************************
  // Product, latency selection and countdown
  // ****************************************************************
  always_comb
  begin
    prod = 64'h0000_0000_0000_0000;
    cycles = coa_pkg::MUL16_CYCLES;
    case (op_in)
      coa_pkg::OP_MULS_W: prod = 64'($signed(a_in[15:0]) * $signed(b_in[15:0]));
      coa_pkg::OP_MULU_W: prod = 64'(a_in[15:0] * b_in[15:0]);
      coa_pkg::OP_MAC_W:
      begin
        prod = acc_in + 64'($signed(a_in[15:0]) * $signed(b_in[15:0]));
        cycles = coa_pkg::MAC16_CYCLES;
      end
      coa_pkg::OP_DMULS_L:
      begin
        prod = 64'($signed(a_in) * $signed(b_in));
        cycles = coa_pkg::MUL32_CYCLES;
      end
      coa_pkg::OP_DMULU_L:
      begin
        prod = {32'h0000_0000, a_in} * {32'h0000_0000, b_in};
        cycles = coa_pkg::MUL32_CYCLES;
      end
      coa_pkg::OP_MAC_L:
      begin
        prod = acc_in + 64'($signed(a_in) * $signed(b_in));
        cycles = coa_pkg::MUL32_CYCLES;
      end
      default: prod = 64'h0000_0000_0000_0000;
    endcase
    cnt_d = cnt_q;
    res_d = res_q;
    done_d = 1'b0;
    // Done stands in the last counted cycle so the core retires on time
    if (start_in)
    begin
      res_d = prod;
      cnt_d = cycles - 3'h1;
      done_d = (cycles == 3'h2);
    end
    else if (cnt_q != 3'h0)
    begin
      cnt_d = cnt_q - 3'h1;
      done_d = (cnt_q == 3'h2);
    end
  end

  // Registers
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= 3'h0;
      done_q <= 1'b0;
      res_q <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      cnt_q <= cnt_d;
      done_q <= done_d;
      res_q <= res_d;
    end
  end

endmodule // coa_mul_unit

// >>> coa_core.sv
// Operand addressing and execution core top level
`timescale 1ns/1ps
module coa_core (
  input wire logic core_clk_in, // Core clock, 100 MHz
  input wire logic reset_n_in, // Asynchronous reset, active low
  input wire logic cmd_valid_in, // Decoded instruction offered
  input wire coa_pkg::coa_cmd_t cmd_in, // Decoded instruction
  input wire coa_pkg::coa_mem_rsp_t mem_rsp_in, // Memory answer
  input wire logic [3:0] dbg_sel_in, // Register to observe
  output logic cmd_ready_out, // Core takes an instruction
  output logic [31:0] pc_out, // Address of next instruction
  output coa_pkg::coa_mem_req_t mem_req_out, // Memory request
  output logic t_flag_out, // Condition flag
  output logic addr_err_out, // Address error pulse
  output logic [31:0] dbg_data_out, // Observed register value
  output logic [63:0] acc_out // Accumulator high and low
);

  logic rst_meta_q, rst_sync_q;
  coa_pkg::coa_state_t state_q, state_d;
  logic [31:0] regs_q [16];
  logic [31:0] regs_d [16];
  logic [31:0] sr_q, sr_d, gbr_q, gbr_d, pc_q, pc_d, tgt_q, tgt_d;
  logic [31:0] ipc_q, ipc_d, dbg_q, dbg_d;
  logic pend_q, pend_d, ready_q, ready_d, err_q, err_d;
  logic [63:0] acc_q, acc_d;
  coa_pkg::coa_mem_req_t req_q, req_d;
  coa_pkg::coa_cmd_t cur_q, cur_d;
  logic [31:0] ea_addr, ea_rn_next;
  logic ea_rn_wr, ea_misalign;
  logic mul_start, mul_done;
  logic [63:0] mul_res;
  logic [31:0] rn_v, rm_v, br_disp8, br_disp12;
  logic take;

  assign cmd_ready_out = ready_q;
  assign pc_out = pc_q;
  assign mem_req_out = req_q;
  assign t_flag_out = sr_q[coa_pkg::T_BIT];
  assign addr_err_out = err_q;
  assign dbg_data_out = dbg_q;
  assign acc_out = acc_q;

  // ****************************************************************
  // Reset release through two flip-flops
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Operand sources and arithmetic units
  // ****************************************************************
  // Operand being issued or held in flight
  always_comb
  begin
    take = ready_q && cmd_valid_in;
    cur_d = take ? cmd_in : cur_q;
    rn_v = regs_q[cur_d.rn];
    rm_v = regs_q[cur_d.rm];
    br_disp8 = {{23{cur_d.disp[7]}}, cur_d.disp[7:0], 1'b0};
    br_disp12 = {{19{cur_d.disp[11]}}, cur_d.disp[11:0], 1'b0};
  end

  coa_ea_unit u_ea (
    .mode_in(cur_d.mode),
    .size_in(cur_d.size),
    .rn_val_in(rn_v),
    .r0_val_in(regs_q[0]),
    .gbr_val_in(gbr_q),
    .pc_val_in(take ? pc_q : ipc_q),
    .disp_in(cur_d.disp[7:0]),
    .addr_out(ea_addr),
    .rn_next_out(ea_rn_next),
    .rn_wr_out(ea_rn_wr),
    .misalign_out(ea_misalign)
  );

  coa_mul_unit u_mul (
    .clk_in(core_clk_in),
    .rst_n_in(rst_sync_q),
    .start_in(mul_start),
    .op_in(cur_d.op),
    .a_in(rn_v),
    .b_in(rm_v),
    .acc_in(acc_q),
    .done_out(mul_done),
    .result_out(mul_res)
  );

  // ****************************************************************
  // Issue, execute and retire
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    regs_d = regs_q;
    sr_d = sr_q;
    gbr_d = gbr_q;
    pc_d = pc_q;
    tgt_d = tgt_q;
    ipc_d = take ? pc_q : ipc_q;
    pend_d = pend_q;
    acc_d = acc_q;
    req_d = req_q;
    err_d = 1'b0;
    ready_d = ready_q;
    mul_start = 1'b0;
    dbg_d = regs_q[dbg_sel_in];
    case (state_q)
      coa_pkg::ST_READY:
      begin
        if (take)
        begin
          // Slot instruction runs, then control moves to the held target
          if (pend_q)
          begin
            pc_d = tgt_q;
            pend_d = 1'b0;
          end
          else
            pc_d = pc_q + coa_pkg::PC_STEP;
          case (cmd_in.op)
            coa_pkg::OP_LOAD, coa_pkg::OP_STORE:
            begin
              if (cmd_in.mode == coa_pkg::AM_DIRECT)
              begin
                if (cmd_in.op == coa_pkg::OP_LOAD)
                  regs_d[cmd_in.rm] = rn_v;
                else
                  regs_d[cmd_in.rn] = rm_v;
              end
              else if (ea_misalign)
                err_d = 1'b1;
              else
              begin
                req_d.valid = 1'b1;
                req_d.write = (cmd_in.op == coa_pkg::OP_STORE);
                req_d.size = cmd_in.size;
                req_d.addr = ea_addr;
                req_d.wdata = rm_v;
                ready_d = 1'b0;
                state_d = coa_pkg::ST_MEM;
              end
            end
            coa_pkg::OP_MOV_IMM: regs_d[cmd_in.rn] = {{24{cmd_in.imm[7]}}, cmd_in.imm};
            coa_pkg::OP_ADD: regs_d[cmd_in.rn] = rn_v + rm_v;
            coa_pkg::OP_ADD_IMM: regs_d[cmd_in.rn] = rn_v + {{24{cmd_in.imm[7]}}, cmd_in.imm};
            coa_pkg::OP_COMPARE_GREATER_EQUAL: sr_d[coa_pkg::T_BIT] = ($signed(rn_v) >= $signed(rm_v));
            coa_pkg::OP_COMPARE_EQUAL: sr_d[coa_pkg::T_BIT] = (rn_v == rm_v);
            coa_pkg::OP_COMPARE_EQUAL_IMM:
              sr_d[coa_pkg::T_BIT] = (rn_v == {{24{cmd_in.imm[7]}}, cmd_in.imm});
            coa_pkg::OP_BRA:
            begin
              // Target is held until the slot instruction has been taken
              if (!pend_q)
              begin
                tgt_d = pc_q + coa_pkg::PC_AHEAD + br_disp12;
                pend_d = 1'b1;
              end
            end
            coa_pkg::OP_BT, coa_pkg::OP_BF:
            begin
              if (!pend_q && (sr_q[coa_pkg::T_BIT] == (cmd_in.op == coa_pkg::OP_BT)))
                pc_d = pc_q + coa_pkg::PC_AHEAD + br_disp8;
            end
            coa_pkg::OP_MULS_W, coa_pkg::OP_MULU_W, coa_pkg::OP_MAC_W,
            coa_pkg::OP_DMULS_L, coa_pkg::OP_DMULU_L, coa_pkg::OP_MAC_L:
            begin
              mul_start = 1'b1;
              ready_d = 1'b0;
              state_d = coa_pkg::ST_MUL;
            end
            default: ready_d = 1'b1;
          endcase
        end
      end
      coa_pkg::ST_MEM:
      begin
        if (mem_rsp_in.ack)
        begin
          req_d.valid = 1'b0;
          ready_d = 1'b1;
          state_d = coa_pkg::ST_READY;
          if (ea_rn_wr)
            regs_d[cur_q.rn] = ea_rn_next;
          if (!req_q.write)
            regs_d[cur_q.rm] = coa_pkg::sext_data(cur_q.size, mem_rsp_in.rdata);
        end
      end
      coa_pkg::ST_MUL:
      begin
        if (mul_done)
        begin
          ready_d = 1'b1;
          state_d = coa_pkg::ST_READY;
          // Sixteen-bit multiply writes only the low half
          if (cur_q.op == coa_pkg::OP_MULS_W || cur_q.op == coa_pkg::OP_MULU_W)
            acc_d[31:0] = mul_res[31:0];
          else
            acc_d = mul_res;
        end
      end
      default:
      begin
        state_d = coa_pkg::ST_READY;
        ready_d = 1'b1;
      end
    endcase
  end

  // Registers
  always_ff @(posedge core_clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      state_q <= coa_pkg::ST_READY;
      for (int i = 0; i < 16; i++)
        regs_q[i] <= coa_pkg::REG_RESET;
      sr_q <= coa_pkg::SR_RESET;
      gbr_q <= coa_pkg::GBR_RESET;
      pc_q <= coa_pkg::PC_RESET;
      tgt_q <= coa_pkg::PC_RESET;
      ipc_q <= coa_pkg::PC_RESET;
      pend_q <= 1'b0;
      acc_q <= 64'h0000_0000_0000_0000;
      req_q <= '0;
      cur_q <= '0;
      err_q <= 1'b0;
      ready_q <= 1'b1;
      dbg_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      regs_q <= regs_d;
      sr_q <= sr_d;
      gbr_q <= gbr_d;
      pc_q <= pc_d;
      tgt_q <= tgt_d;
      ipc_q <= ipc_d;
      pend_q <= pend_d;
      acc_q <= acc_d;
      req_q <= req_d;
      cur_q <= cur_d;
      err_q <= err_d;
      ready_q <= ready_d;
      dbg_q <= dbg_d;
    end
  end

endmodule // coa_core

// >>> coa_core_checker.sv
// Concurrent checks on the ports of the operand addressing core
`timescale 1ns/1ps
module coa_core_checker (
  input wire logic core_clk_in, // Core clock
  input wire logic reset_n_in, // Reset, active low
  input wire logic cmd_valid_in, // Command offered
  input wire coa_pkg::coa_cmd_t cmd_in, // Command
  input wire coa_pkg::coa_mem_rsp_t mem_rsp_in, // Memory answer
  input wire logic cmd_ready_out, // Core ready
  input wire logic [31:0] pc_out, // Next fetch address
  input wire coa_pkg::coa_mem_req_t mem_req_out, // Memory request
  input wire logic t_flag_out, // Condition flag
  input wire logic addr_err_out // Address error
);
  logic tk;
  coa_pkg::coa_op_t op;
  // Command taken this cycle
  assign tk = cmd_valid_in && cmd_ready_out;
  assign op = cmd_in.op;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_bra_slot;
    tk && op == coa_pkg::OP_BRA |=> pc_out == $past(pc_out) + 32'h0000_0002;
  endproperty
  a_bra_slot: assert property (p_bra_slot) else $error("Slot address not next");
  property p_mul16;
    tk && op inside {coa_pkg::OP_MULS_W, coa_pkg::OP_MULU_W} |-> ##[1:2] cmd_ready_out;
  endproperty
  a_mul16: assert property (p_mul16) else $error("Short multiply too slow");
  property p_mac16;
    tk && op == coa_pkg::OP_MAC_W |=> !cmd_ready_out ##[1:2] cmd_ready_out;
  endproperty
  a_mac16: assert property (p_mac16) else $error("Short accumulate timing");
  property p_mul32;
    tk && op inside {coa_pkg::OP_DMULS_L, coa_pkg::OP_DMULU_L, coa_pkg::OP_MAC_L}
      |=> !cmd_ready_out ##[1:3] cmd_ready_out;
  endproperty
  a_mul32: assert property (p_mul32) else $error("Long multiply timing");
  property p_add_flag;
    tk && op inside {coa_pkg::OP_ADD, coa_pkg::OP_ADD_IMM} |=> $stable(t_flag_out);
  endproperty
  a_add_flag: assert property (p_add_flag) else $error("Add changed flag");
  property p_direct;
    tk && op inside {coa_pkg::OP_LOAD, coa_pkg::OP_STORE} && cmd_in.mode == coa_pkg::AM_DIRECT
      |=> !mem_req_out.valid [*2];
  endproperty
  a_direct: assert property (p_direct) else $error("Direct mode used memory");
  property p_hold;
    mem_req_out.valid && !mem_rsp_in.ack |=> $stable(mem_req_out);
  endproperty
  a_hold: assert property (p_hold) else $error("Request changed before answer");
  property p_align;
    mem_req_out.valid |-> !(mem_req_out.size == coa_pkg::SZ_WORD && mem_req_out.addr[0])
      && !(mem_req_out.size == coa_pkg::SZ_LONG && mem_req_out.addr[1:0] != 2'b00);
  endproperty
  a_align: assert property (p_align) else $error("Misaligned request issued");
  property p_err_noreq;
    addr_err_out |-> !mem_req_out.valid;
  endproperty
  a_err_noreq: assert property (p_err_noreq) else $error("Request beside error");
  // Main scenarios reached
  c_bra: cover property (tk && op == coa_pkg::OP_BRA);
  c_mac: cover property (tk && op == coa_pkg::OP_MAC_L);
  c_err: cover property (addr_err_out);
endmodule // coa_core_checker

// >>> coa_mem_model.sv
// Behavioural on-chip bus and operand memory facing the core
`timescale 1ns/1ps
module coa_mem_model (
  input wire logic clk_in, // Core clock
  input wire logic rst_n_in, // Reset, active low
  input wire coa_pkg::coa_mem_req_t req_in, // Request from core
  output coa_pkg::coa_mem_rsp_t rsp_out // Answer to core
);
  int wait_q;
  // Answer after 0 to 3 cycles; data lines toggle outside the answer
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rsp_out <= '0;
      wait_q <= 0;
    end
    else
    begin
      rsp_out.ack <= 1'b0;
      rsp_out.rdata <= ~rsp_out.rdata;
      if (req_in.valid && !rsp_out.ack && wait_q == 0)
      begin
        rsp_out.ack <= 1'b1;
        rsp_out.rdata <= $urandom;
        wait_q <= $urandom_range(3, 0);
      end
      else if (req_in.valid && !rsp_out.ack)
        wait_q <= wait_q - 1;
    end
  end
endmodule // coa_mem_model

// >>> test_cpu_operand_addressing.sv
// Self-checking bench for the operand addressing core
`timescale 1ns/1ps
module test_cpu_operand_addressing;
  logic clk, rst_n, vld, tf, aerr, rdy, mt, st;
  logic [3:0] sel, gn, gm;
  logic [7:0] im;
  logic [11:0] d12;
  coa_pkg::coa_cmd_t cmd;
  coa_pkg::coa_mem_rsp_t rsp;
  coa_pkg::coa_mem_req_t req;
  logic [31:0] pc, dbg, mpc, a, b, tgt, mr[16], qa[$], qd[$], qw[$];
  logic [63:0] acc, macc;
  int n_fail, checked, cyc, n_err, lowc, k;
  int lo[6] = '{1, 1, 2, 2, 2, 2};
  int hi[6] = '{2, 2, 3, 4, 4, 4};
  coa_pkg::coa_op_t fl[6] = '{coa_pkg::OP_COMPARE_GREATER_EQUAL, coa_pkg::OP_COMPARE_EQUAL, coa_pkg::OP_COMPARE_EQUAL_IMM,
    coa_pkg::OP_ADD, coa_pkg::OP_ADD_IMM, coa_pkg::OP_MOV_IMM};
  coa_pkg::coa_op_t mo[6] = '{coa_pkg::OP_MULS_W, coa_pkg::OP_MULU_W, coa_pkg::OP_MAC_W,
    coa_pkg::OP_DMULS_L, coa_pkg::OP_DMULU_L, coa_pkg::OP_MAC_L};
  coa_core dut (.core_clk_in(clk), .reset_n_in(rst_n), .cmd_valid_in(vld), .cmd_in(cmd),
    .mem_rsp_in(rsp), .dbg_sel_in(sel), .cmd_ready_out(rdy), .pc_out(pc), .mem_req_out(req),
    .t_flag_out(tf), .addr_err_out(aerr), .dbg_data_out(dbg), .acc_out(acc));
  coa_mem_model mem (.clk_in(clk), .rst_n_in(rst_n), .req_in(req), .rsp_out(rsp));
  // ****************************************************************
  // Clock, capture, timeout and helpers
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Record finished transfers and error pulses
  always @(posedge clk)
  begin
    cyc++;
    if (req.valid && rsp.ack)
    begin
      qa.push_back(req.addr);
      qd.push_back(rsp.rdata);
      qw.push_back(req.wdata);
    end
    if (aerr)
      n_err++;
    if (cyc == 30000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] sx8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Offer one command, wait for it to retire
  task automatic issue(input coa_pkg::coa_op_t op, input logic [2:0] md, input logic [1:0] sz,
    input logic [3:0] rn, input logic [3:0] rm, input logic [11:0] d, input logic [7:0] i);
    lowc = 0;
    while (rdy !== 1'b1 && lowc < 50)
    begin
      lowc++;
      @(negedge clk);
    end
    cmd = '{op, coa_pkg::coa_mode_t'(md), coa_pkg::coa_size_t'(sz), rn, rm, d, i};
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    lowc = 0;
    while (rdy !== 1'b1 && lowc < 50)
    begin
      lowc++;
      @(negedge clk);
    end
    if (lowc >= 50)
      n_fail++;
    mpc += 32'h0000_0002;
  endtask
  task automatic chk_regs();
    for (int i = 0; i < 16; i++)
    begin
      sel = 4'(i);
      @(negedge clk);
      @(negedge clk);
      chk(dbg, mr[i]);
    end
  endtask
  // Load or store in one mode, compared with the address model
  task automatic mem_op(input logic s, input logic [2:0] md, input logic [1:0] sz,
    input logic [3:0] rn, input logic [3:0] rm, input logic [11:0] d);
    logic [31:0] ea, stp, dat, msk;
    logic mis;
    int e0;
    stp = 32'h0000_0001 << sz;
    case (md)
      3'd3: ea = mr[rn] - stp;
      3'd4: ea = mr[rn] + ({28'h000_0000, d[3:0]} << sz);
      3'd5: ea = mr[rn] + mr[0];
      3'd6: ea = {24'h00_0000, d[7:0]} << sz;
      3'd7: ea = (mpc + 32'h0000_0004 & {30'h3fff_ffff, {2{sz != 2'd2}}}) + (d[7:0] << sz);
      default: ea = mr[rn];
    endcase
    mis = md != 3'd0 && ((sz == 2'd1 && ea[0]) || (sz == 2'd2 && ea[1:0] != 2'd0));
    msk = sz == 2'd0 ? 32'h0000_00ff : sz == 2'd1 ? 32'h0000_ffff : 32'hffff_ffff;
    e0 = n_err;
    issue(s ? coa_pkg::OP_STORE : coa_pkg::OP_LOAD, md, sz, rn, rm, d, 8'h00);
    @(negedge clk);
    chk(n_err - e0, mis);
    chk(qa.size(), !mis && md != 3'd0);
    if (md == 3'd0)
      if (s)
        mr[rn] = mr[rm];
      else
        mr[rm] = mr[rn];
    else if (qa.size() != 0)
    begin
      chk(qa.pop_front(), ea);
      dat = qd.pop_front();
      if (s)
        chk(qw.pop_front() & msk, mr[rm] & msk);
      else
        void'(qw.pop_front());
      if (md == 3'd2)
        mr[rn] += stp;
      if (md == 3'd3)
        mr[rn] = ea;
      if (!s)
        mr[rm] = sz == 2'd0 ? sx8(dat[7:0]) : sz == 2'd1 ? {{16{dat[15]}}, dat[15:0]} : dat;
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst_n = 1'b0;
    vld = 1'b0;
    sel = 4'h0;
    cmd = '0;
    mpc = 32'h0000_0000;
    macc = 64'h0000_0000_0000_0000;
    void'($urandom(32'hd70dc1b1));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 16; i++)
    begin
      im = 8'($urandom) & 8'hfc;
      issue(coa_pkg::OP_MOV_IMM, 3'd0, 2'd0, 4'(i), 4'h0, 12'h000, im);
      mr[i] = sx8(im);
    end
    for (int i = 15; i >= 0; i--)
      mem_op(1'b0, 3'd1, 2'd2, i == 0 ? 4'h1 : 4'h0, 4'(i), 12'h000);
    chk_regs();
    $display("Test register setup done");
    repeat (48)
    begin
      mem_op(1'($urandom), 3'($urandom_range(7, 0)), 2'($urandom_range(2, 0)), 4'($urandom),
        4'($urandom), 12'($urandom));
      chk_regs();
    end
    $display("Test addressing modes done");
    for (int i = 0; i < 24; i++)
    begin
      k = i % 6;
      gn = 4'($urandom_range(3, 0));
      gm = 4'($urandom_range(3, 0));
      im = 8'($urandom_range(3, 0));
      issue(fl[k], 3'd0, 2'd2, gn, gm, 12'h000, im);
      case (k)
        0: mt = $signed(mr[gn]) >= $signed(mr[gm]);
        1: mt = mr[gn] == mr[gm];
        2: mt = mr[gn] == sx8(im);
        3: mr[gn] += mr[gm];
        4: mr[gn] += sx8(im);
        default: mr[gn] = sx8(im);
      endcase
      chk(tf, mt);
    end
    chk_regs();
    $display("Test condition flag done");
    mpc = pc;
    issue(coa_pkg::OP_MOV_IMM, 3'd0, 2'd2, 4'h2, 4'h0, 12'h000, 8'h05);
    mr[2] = 32'h0000_0005;
    for (int i = 0; i < 12; i++)
    begin
      im = 8'($urandom_range(5, 4));
      issue(coa_pkg::OP_COMPARE_EQUAL_IMM, 3'd0, 2'd2, 4'h2, 4'h0, 12'h000, im);
      mt = im == 8'h05;
      d12 = 12'($urandom);
      k = i % 3;
      tgt = mpc + 32'h0000_0004 + (k == 0 ? {{19{d12[11]}}, d12, 1'b0} : {{23{d12[7]}}, d12[7:0], 1'b0});
      issue(k == 0 ? coa_pkg::OP_BRA : k == 1 ? coa_pkg::OP_BT : coa_pkg::OP_BF, 3'd0, 2'd2,
        4'h0, 4'h0, d12, 8'h00);
      if (k == 0)
      begin
        chk(pc, mpc);
        issue(coa_pkg::OP_ADD_IMM, 3'd0, 2'd2, 4'h1, 4'h0, 12'h000, 8'h01);
        mr[1] += 32'h0000_0001;
        mpc = tgt;
      end
      else if (mt == (k == 1))
        mpc = tgt;
      chk(pc, mpc);
    end
    chk_regs();
    $display("Test branches done");
    for (int i = 0; i < 12; i++)
    begin
      k = i % 6;
      gn = 4'($urandom);
      gm = 4'($urandom);
      a = mr[gn];
      b = mr[gm];
      issue(mo[k], 3'd0, 2'd2, gn, gm, 12'h000, 8'h00);
      case (k)
        0: macc[31:0] = 32'(int'($signed(a[15:0])) * int'($signed(b[15:0])));
        1: macc[31:0] = a[15:0] * b[15:0];
        2: macc += longint'($signed(a[15:0])) * longint'($signed(b[15:0]));
        3: macc = longint'($signed(a)) * longint'($signed(b));
        4: macc = {32'h0000_0000, a} * {32'h0000_0000, b};
        default: macc += longint'($signed(a)) * longint'($signed(b));
      endcase
      chk(acc, macc);
      chk(lowc + 1 >= lo[k] && lowc + 1 <= hi[k], 1'b1);
    end
    $display("Test multiply done");
    stop_test();
  end
endmodule // test_cpu_operand_addressing
bind coa_core coa_core_checker u_chk (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .mem_rsp_in(mem_rsp_in),
  .cmd_ready_out(cmd_ready_out), .pc_out(pc_out), .mem_req_out(mem_req_out),
  .t_flag_out(t_flag_out), .addr_err_out(addr_err_out));
